// ==== logic/xeb_bus.sv ====
`timescale 1ns/1ps
module xeb_bus
  import xeb_pkg::*;
#(
  parameter logic [16:0] P_ROM_END  = 17'h08000,
  parameter logic [16:0] P_INT_BASE = 17'h0f800
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_clk_en,
  input  wire logic        i_reset,
  // cpu access port
  input  wire logic        i_cpu_req,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [7:0]  i_cpu_wdata,
  input  wire logic        i_cpu_we,
  input  wire logic        i_cpu_rmw,
  output logic             o_cpu_ack,
  output logic [7:0]       o_cpu_rdata,
  output logic             o_cpu_ext,
  output logic [7:0]       o_cfg,
  // port latches from the port logic
  input  wire logic [7:0]  i_p4_latch,
  input  wire logic [7:0]  i_p5_latch,
  input  wire logic [7:0]  i_p5_dir,
  input  wire logic [3:0]  i_p6u_latch,
  input  wire logic [3:0]  i_p6u_dir,
  input  wire logic [3:0]  i_p6l_latch,
  input  wire logic [3:0]  i_p6l_dir,
  // pins
  input  wire logic [7:0]  i_p4_in,
  output logic [7:0]       o_p4_out,
  output logic [7:0]       o_p4_oe,
  output logic [7:0]       o_p5_out,
  output logic [7:0]       o_p5_oe,
  input  wire logic [3:0]  i_p6u_in,
  output logic [3:0]       o_p6u_out,
  output logic [3:0]       o_p6u_oe,
  output logic [3:0]       o_p6l_out,
  output logic [3:0]       o_p6l_oe
);

  // ------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------
  function automatic logic f_expansion(input logic [2:0] m);
    f_expansion = (m == XEB_MODE_256) || (m == XEB_MODE_4K) ||
                  (m == XEB_MODE_16K) || (m == XEB_MODE_FULL);
  endfunction : f_expansion

  function automatic logic [7:0] f_hi_mask(input logic [2:0] m);
    case (m)
      XEB_MODE_4K:   f_hi_mask = 8'h0f;
      XEB_MODE_16K:  f_hi_mask = 8'h3f;
      XEB_MODE_FULL: f_hi_mask = 8'hff;
      default:       f_hi_mask = 8'h00;
    endcase
  endfunction : f_hi_mask

  function automatic logic f_is_ext(input logic [2:0] m,
                                    input logic [15:0] a);
    logic [16:0] span;
    logic [16:0] a17;
    span = 17'h00000;
    a17  = {1'b0, a};
    case (m)
      XEB_MODE_256:  span = XEB_SPAN_256;
      XEB_MODE_4K:   span = XEB_SPAN_4K;
      XEB_MODE_16K:  span = XEB_SPAN_16K;
      XEB_MODE_FULL: span = XEB_SPAN_FULL;
      default:       span = 17'h00000;
    endcase
    // internal rom below, internal ram/sfr/reserved above
    f_is_ext = f_expansion(m) && (a17 >= P_ROM_END) &&
               (a17 < P_INT_BASE) &&
               ({1'b0, a17} < ({1'b0, P_ROM_END} + {1'b0, span}));
  endfunction : f_is_ext

  // ------------------------------------------------------------
  // pin input synchroniser
  // ------------------------------------------------------------
  xeb_sync_if #(.W(9)) sif ();
  assign sif.raw = {i_p6u_in[XEB_PIN_WAIT], i_p4_in};

  xeb_sync #(.W(9)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_clk_en  (i_clk_en),
    .i_reset   (i_reset),
    .s         (sif)
  );

  logic [7:0] p4_sync;
  logic       wait_n_sync;
  assign p4_sync     = sif.clean[7:0];
  assign wait_n_sync = sif.clean[8];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  xeb_state_t  state_reg;
  logic [1:0]  cnt_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic        we_reg;
  logic        rmw_reg;
  logic        wphase_reg;
  logic        ext_reg;
  logic [7:0]  cfg_reg;
  logic [2:0]  mode;
  logic [1:0]  wmode;

  assign mode  = cfg_reg[XEB_MODE_LSB +: 3];
  assign wmode = cfg_reg[XEB_WAIT_LSB +: 2];

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= XEB_ST_IDLE;
      cnt_reg   <= 2'h0;
    end else if (i_clk_en) begin
      case (state_reg)
        XEB_ST_IDLE: begin
          if (i_cpu_req) begin
            if (f_expansion(mode)) begin
              state_reg <= XEB_ST_ADDR;
              cnt_reg   <= XEB_ADDR_CYC - 2'h1;
            end else begin
              state_reg <= XEB_ST_END;
            end
          end
        end
        XEB_ST_ADDR: begin
          if (cnt_reg == 2'h0) begin
            state_reg <= XEB_ST_LATCH;
            cnt_reg   <= XEB_LATCH_CYC - 2'h1;
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        XEB_ST_LATCH: begin
          if (cnt_reg != 2'h0) begin
            cnt_reg <= cnt_reg - 2'h1;
          end else if (ext_reg) begin
            state_reg <= XEB_ST_STROBE;
            cnt_reg   <= XEB_STROBE_CYC - 2'h1;
          end else begin
            state_reg <= XEB_ST_END;
          end
        end
        XEB_ST_STROBE: begin
          if (cnt_reg != 2'h0) begin
            cnt_reg <= cnt_reg - 2'h1;
          end else if (wmode == XEB_WAIT_ONE) begin
            state_reg <= XEB_ST_WAIT1;
          end else if (wmode == XEB_WAIT_PIN) begin
            state_reg <= XEB_ST_EXTW;
          end else begin
            state_reg <= XEB_ST_END;
          end
        end
        XEB_ST_WAIT1: state_reg <= XEB_ST_END;
        XEB_ST_EXTW: begin
          if (wait_n_sync) begin
            state_reg <= XEB_ST_END;
          end
        end
        XEB_ST_END: begin
          if (ext_reg && rmw_reg && !wphase_reg) begin
            state_reg <= XEB_ST_STROBE;
            cnt_reg   <= XEB_STROBE_CYC - 2'h1;
          end else begin
            state_reg <= XEB_ST_IDLE;
          end
        end
        default: state_reg <= XEB_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // access capture
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      addr_reg   <= 16'h0000;
      wdata_reg  <= 8'h00;
      we_reg     <= 1'b0;
      rmw_reg    <= 1'b0;
      wphase_reg <= 1'b0;
      ext_reg    <= 1'b0;
    end else if (i_clk_en) begin
      if (state_reg == XEB_ST_IDLE && i_cpu_req) begin
        addr_reg   <= i_cpu_addr;
        wdata_reg  <= i_cpu_wdata;
        we_reg     <= i_cpu_we;
        rmw_reg    <= i_cpu_rmw;
        wphase_reg <= i_cpu_we && !i_cpu_rmw;
        ext_reg    <= f_is_ext(mode, i_cpu_addr);
      end else if (state_reg == XEB_ST_END && rmw_reg) begin
        wphase_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration register and cpu answer
  // ------------------------------------------------------------
  logic cfg_hit;
  assign cfg_hit = !ext_reg && (addr_reg == XEB_CFG_ADDR);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cfg_reg <= XEB_CFG_RESET;
    end else if (i_clk_en && state_reg == XEB_ST_END && cfg_hit &&
                 (we_reg || rmw_reg)) begin
      cfg_reg <= wdata_reg & XEB_CFG_WR_MASK;
    end
  end

  logic done;
  assign done = (state_reg == XEB_ST_END) &&
                !(ext_reg && rmw_reg && !wphase_reg);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_cpu_ack   <= 1'b0;
      o_cpu_rdata <= 8'h00;
      o_cpu_ext   <= 1'b0;
      o_cfg       <= XEB_CFG_RESET;
    end else if (i_clk_en) begin
      o_cpu_ack <= done;
      o_cfg     <= cfg_reg;
      if (state_reg == XEB_ST_END && !wphase_reg) begin
        o_cpu_ext <= ext_reg;
        if (ext_reg) begin
          o_cpu_rdata <= p4_sync;
        end else if (cfg_hit) begin
          o_cpu_rdata <= cfg_reg;
        end else begin
          o_cpu_rdata <= 8'h00;
        end
      end else if (done) begin
        o_cpu_ext <= ext_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  logic       in_cycle;
  logic       strobing;
  logic       drive_wdata;
  logic [7:0] hi_mask;
  assign in_cycle    = (state_reg != XEB_ST_IDLE);
  assign strobing    = ext_reg && ((state_reg == XEB_ST_STROBE) ||
                       (state_reg == XEB_ST_WAIT1) ||
                       (state_reg == XEB_ST_EXTW));
  assign drive_wdata = ext_reg && wphase_reg &&
                       (strobing || state_reg == XEB_ST_END);
  assign hi_mask     = f_hi_mask(mode);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_p4_out  <= 8'h00;
      o_p4_oe   <= 8'h00;
      o_p5_out  <= 8'h00;
      o_p5_oe   <= 8'h00;
      o_p6u_out <= 4'h0;
      o_p6u_oe  <= 4'h0;
      o_p6l_out <= 4'h0;
      o_p6l_oe  <= 4'h0;
    end else if (i_clk_en) begin
      o_p6l_out <= i_p6l_latch;
      o_p6l_oe  <= i_p6l_dir;
      if (!f_expansion(mode)) begin
        o_p4_out <= i_p4_latch;
        o_p4_oe  <= (mode == XEB_MODE_SC_OUT) ? 8'hff : 8'h00;
        o_p5_out <= i_p5_latch;
        o_p5_oe  <= i_p5_dir;
        o_p6u_out <= i_p6u_latch;
        o_p6u_oe  <= i_p6u_dir;
      end else begin
        // data pins carry the low address byte, driven, on internal cycles
        if (drive_wdata || (ext_reg && rmw_reg &&
            state_reg == XEB_ST_END)) begin
          o_p4_out <= wdata_reg;
          o_p4_oe  <= 8'hff;
        end else if (strobing) begin
          o_p4_out <= addr_reg[7:0];
          o_p4_oe  <= 8'h00;
        end else begin
          o_p4_out <= addr_reg[7:0];
          o_p4_oe  <= 8'hff;
        end
        o_p5_out <= (addr_reg[15:8] & hi_mask) |
                    (i_p5_latch & ~hi_mask);
        o_p5_oe  <= hi_mask | (i_p5_dir & ~hi_mask);
        o_p6u_out[XEB_PIN_RD] <= !(strobing && !wphase_reg);
        o_p6u_out[XEB_PIN_WR] <= !(strobing && wphase_reg);
        o_p6u_out[XEB_PIN_ADDRESS_LATCH_STROBE] <= (state_reg == XEB_ST_ADDR);
        o_p6u_oe[XEB_PIN_RD]    <= 1'b1;
        o_p6u_oe[XEB_PIN_WR]    <= 1'b1;
        o_p6u_oe[XEB_PIN_ADDRESS_LATCH_STROBE]  <= 1'b1;
        if (wmode == XEB_WAIT_PIN) begin
          o_p6u_out[XEB_PIN_WAIT] <= 1'b0;
          o_p6u_oe[XEB_PIN_WAIT]  <= 1'b0;
        end else begin
          o_p6u_out[XEB_PIN_WAIT] <= i_p6u_latch[XEB_PIN_WAIT];
          o_p6u_oe[XEB_PIN_WAIT]  <= i_p6u_dir[XEB_PIN_WAIT];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  property p_reset_cfg;
    $past(i_reset) |-> cfg_reg == XEB_CFG_RESET;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("config register not at reset value");

  property p_address_latch_strobe_start;
    state_reg == XEB_ST_IDLE && i_cpu_req && i_clk_en &&
      f_expansion(mode) ##1 i_clk_en |-> ##1 o_p6u_out[XEB_PIN_ADDRESS_LATCH_STROBE];
  endproperty
  a_address_latch_strobe_start: assert property (p_address_latch_strobe_start)
    else $error("latch strobe missing at cycle start");

  property p_no_strobe_int;
    !ext_reg && in_cycle && i_clk_en && f_expansion(mode) |=>
      o_p6u_out[XEB_PIN_RD] && o_p6u_out[XEB_PIN_WR];
  endproperty
  a_no_strobe_int: assert property (p_no_strobe_int)
    else $error("strobe active on internal access");

  property p_wr_only_write;
    $past(f_expansion(mode)) && !o_p6u_out[XEB_PIN_WR] |->
      $past(ext_reg) && $past(wphase_reg);
  endproperty
  a_wr_only_write: assert property (p_wr_only_write)
    else $error("write strobe without external write");

  property p_wait1;
    state_reg == XEB_ST_WAIT1 |->
      $past(state_reg) == XEB_ST_STROBE && wmode == XEB_WAIT_ONE;
  endproperty
  a_wait1: assert property (p_wait1)
    else $error("wait state without one-wait setting");

  property p_extw_ext;
    state_reg == XEB_ST_EXTW |-> ext_reg && wmode == XEB_WAIT_PIN;
  endproperty
  a_extw_ext: assert property (p_extw_ext)
    else $error("pin wait on internal access");

  property p_extw_exit;
    state_reg == XEB_ST_EXTW && wait_n_sync && i_clk_en |=>
      state_reg == XEB_ST_END;
  endproperty
  a_extw_exit: assert property (p_extw_exit)
    else $error("cycle not ended after wait released");

  property p_rmw;
    state_reg == XEB_ST_END && ext_reg && rmw_reg && !wphase_reg &&
      i_clk_en |=> state_reg == XEB_ST_STROBE && wphase_reg;
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("read-modify-write missed its write");

  property p_sc_in;
    mode == XEB_MODE_SC_IN && i_clk_en |=> o_p4_oe == 8'h00;
  endproperty
  a_sc_in: assert property (p_sc_in)
    else $error("port 4 driven in input single-chip mode");

  property p_lower_port;
    i_clk_en |=> o_p6l_oe == $past(i_p6l_dir);
  endproperty
  a_lower_port: assert property (p_lower_port)
    else $error("port 6 lower pins left port mode");

  c_ext_read:  cover property (state_reg == XEB_ST_END && ext_reg &&
                               !we_reg);
  c_ext_write: cover property (state_reg == XEB_ST_END && ext_reg &&
                               we_reg && !rmw_reg);
  c_pin_wait:  cover property (state_reg == XEB_ST_EXTW [*3]);
  c_rmw:       cover property (state_reg == XEB_ST_STROBE && rmw_reg &&
                               wphase_reg);

endmodule : xeb_bus

// ==== logic/xeb_pkg.sv ====
package xeb_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] XEB_CFG_ADDR     = 16'hfff8;
  localparam logic [7:0]  XEB_CFG_RESET    = 8'h10;
  localparam logic [7:0]  XEB_CFG_WR_MASK  = 8'h37;
  localparam int          XEB_MODE_LSB     = 0;
  localparam int          XEB_WAIT_LSB     = 4;

  // ------------------------------------------------------------
  // bus mode codes
  // ------------------------------------------------------------
  localparam logic [2:0] XEB_MODE_SC_IN   = 3'h0;
  localparam logic [2:0] XEB_MODE_SC_OUT  = 3'h1;
  localparam logic [2:0] XEB_MODE_256     = 3'h3;
  localparam logic [2:0] XEB_MODE_4K      = 3'h4;
  localparam logic [2:0] XEB_MODE_16K     = 3'h5;
  localparam logic [2:0] XEB_MODE_FULL    = 3'h7;

  // ------------------------------------------------------------
  // wait codes
  // ------------------------------------------------------------
  localparam logic [1:0] XEB_WAIT_NONE    = 2'h0;
  localparam logic [1:0] XEB_WAIT_ONE     = 2'h1;
  localparam logic [1:0] XEB_WAIT_PIN     = 2'h3;

  // ------------------------------------------------------------
  // expansion spans and cycle timing
  // ------------------------------------------------------------
  localparam logic [16:0] XEB_SPAN_256    = 17'h00100;
  localparam logic [16:0] XEB_SPAN_4K     = 17'h01000;
  localparam logic [16:0] XEB_SPAN_16K    = 17'h04000;
  localparam logic [16:0] XEB_SPAN_FULL   = 17'h10000;
  localparam logic [1:0]  XEB_ADDR_CYC    = 2'h2;
  localparam logic [1:0]  XEB_LATCH_CYC   = 2'h1;
  localparam logic [1:0]  XEB_STROBE_CYC  = 2'h3;

  // upper port 6 pin positions
  localparam int XEB_PIN_RD   = 0;
  localparam int XEB_PIN_WR   = 1;
  localparam int XEB_PIN_WAIT = 2;
  localparam int XEB_PIN_ADDRESS_LATCH_STROBE = 3;

  typedef enum logic [2:0] {
    XEB_ST_IDLE,
    XEB_ST_ADDR,
    XEB_ST_LATCH,
    XEB_ST_STROBE,
    XEB_ST_WAIT1,
    XEB_ST_EXTW,
    XEB_ST_END
  } xeb_state_t;

endpackage : xeb_pkg

// ==== logic/xeb_sync.sv ====
`timescale 1ns/1ps
module xeb_sync
  import xeb_pkg::*;
#(
  parameter int W = 9
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_clk_en,
  input  wire logic i_reset,
  // pins in, synchronised out
  xeb_sync_if.sync  s
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] clean_reg;

  // two stages; the first is read by the second only
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_reg  <= '0;
      clean_reg <= '0;
    end else if (i_clk_en) begin
      meta_reg  <= s.raw;
      clean_reg <= meta_reg;
    end
  end

  assign s.clean = clean_reg;

endmodule : xeb_sync

// ==== logic/xeb_sync_if.sv ====
`timescale 1ns/1ps
interface xeb_sync_if #(parameter int W = 9);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport user (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : xeb_sync_if

// ==== tb/xeb_bus_tb.sv ====
`timescale 1ns/1ps
module xeb_bus_tb
  import xeb_pkg::*;
;
  logic        i_ref_clk   = 1'b0;
  logic        i_clk_en    = 1'b1;
  logic        i_reset     = 1'b1;
  logic        i_cpu_req   = 1'b0;
  logic [15:0] i_cpu_addr  = 16'h0000;
  logic [7:0]  i_cpu_wdata = 8'h00;
  logic        i_cpu_we    = 1'b0;
  logic        i_cpu_rmw   = 1'b0;
  logic [7:0]  i_p4_latch  = 8'ha5;
  logic [7:0]  i_p5_latch  = 8'h80;
  logic [7:0]  i_p5_dir    = 8'h00;
  logic [3:0]  i_p6u_latch = 4'h4;
  logic [3:0]  i_p6u_dir   = 4'h4;
  logic [3:0]  i_p6l_latch = 4'ha;
  logic [3:0]  i_p6l_dir   = 4'h5;
  logic [7:0]  wait_len    = 8'h0a;
  logic [7:0]  rd_lo, wr_lo, address_latch_strobe_hi;
  int          n_fail      = 0;
  int          cmp_count   = 0;
  logic        o_cpu_ack, o_cpu_ext, wait_n;
  logic [7:0]  o_cpu_rdata, o_cfg, o_p4_out, o_p4_oe, o_p5_out, o_p5_oe;
  logic [7:0]  i_p4_in, mdl_p4;
  logic [3:0]  i_p6u_in, o_p6u_out, o_p6u_oe, o_p6l_out, o_p6l_oe;

  always #2.5 i_ref_clk = ~i_ref_clk;

  // pin levels: device where enabled, else far side or pull-up
  assign i_p4_in  = (o_p4_oe & o_p4_out) | (~o_p4_oe & mdl_p4);
  assign i_p6u_in = (o_p6u_oe & o_p6u_out)
                  | (~o_p6u_oe & {1'b1, wait_n, 2'b11});

  xeb_bus xeb_bus_i (
    .i_ref_clk(i_ref_clk), .i_clk_en(i_clk_en), .i_reset(i_reset),
    .i_cpu_req(i_cpu_req), .i_cpu_addr(i_cpu_addr),
    .i_cpu_wdata(i_cpu_wdata), .i_cpu_we(i_cpu_we),
    .i_cpu_rmw(i_cpu_rmw), .o_cpu_ack(o_cpu_ack),
    .o_cpu_rdata(o_cpu_rdata), .o_cpu_ext(o_cpu_ext), .o_cfg(o_cfg),
    .i_p4_latch(i_p4_latch), .i_p5_latch(i_p5_latch),
    .i_p5_dir(i_p5_dir), .i_p6u_latch(i_p6u_latch),
    .i_p6u_dir(i_p6u_dir), .i_p6l_latch(i_p6l_latch),
    .i_p6l_dir(i_p6l_dir), .i_p4_in(i_p4_in), .o_p4_out(o_p4_out),
    .o_p4_oe(o_p4_oe), .o_p5_out(o_p5_out), .o_p5_oe(o_p5_oe),
    .i_p6u_in(i_p6u_in), .o_p6u_out(o_p6u_out), .o_p6u_oe(o_p6u_oe),
    .o_p6l_out(o_p6l_out), .o_p6l_oe(o_p6l_oe));

  xeb_mem_model xeb_mem_model_i (
    .i_ref_clk(i_ref_clk), .i_p4_out(o_p4_out), .i_p6u_out(o_p6u_out),
    .i_p6u_oe(o_p6u_oe), .i_wait_len(wait_len), .o_p4_in(mdl_p4),
    .o_wait_n(wait_n));

  // strobe activity of the current access
  always @(posedge i_ref_clk) begin
    if (o_p6u_oe[0] && o_p6u_out[0] === 1'b0) rd_lo++;
    if (o_p6u_oe[1] && o_p6u_out[1] === 1'b0) wr_lo++;
    if (o_p6u_oe[3] && o_p6u_out[3] === 1'b1) address_latch_strobe_hi++;
  end

  // -----------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic [15:0] a, input logic we,
                     input logic rmw, input logic [7:0] wd,
                     output logic [7:0] lat);
    int n;
    @(posedge i_ref_clk);
    #1;
    rd_lo       = 8'h00;
    wr_lo       = 8'h00;
    address_latch_strobe_hi     = 8'h00;
    i_cpu_addr  = a;
    i_cpu_we    = we;
    i_cpu_rmw   = rmw;
    i_cpu_wdata = wd;
    i_cpu_req   = 1'b1;
    // taken at the first idle edge; holding it longer starts a second
    // access on the edge where ack is seen
    @(posedge i_ref_clk);
    #1;
    i_cpu_req = 1'b0;
    n = 1;
    while (o_cpu_ack !== 1'b1 && n < 100) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (o_cpu_ack !== 1'b1) begin
      n_fail++;
      $display("ERROR t=%0t ack=%h exp=%h", $time, o_cpu_ack, 1'b1);
    end
    lat = 8'(n);
  endtask : acc

  task automatic setcfg(input logic [2:0] m, input logic [1:0] w);
    logic [7:0] l;
    acc(XEB_CFG_ADDR, 1'b1, 1'b0, {2'b00, w, 1'b0, m}, l);
    @(posedge i_ref_clk);
    #1;
    chk(o_cfg, {2'b00, w, 1'b0, m});
  endtask : setcfg

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_cfg;
    logic [7:0] l;
    acc(XEB_CFG_ADDR, 1'b1, 1'b0, 8'hff, l);
    chk(l, 8'h02);
    acc(XEB_CFG_ADDR, 1'b0, 1'b0, 8'h00, l);
    chk(o_cpu_rdata, 8'h37);
    chk(l, 8'h05);
    chk({7'h0, o_cpu_ext}, 8'h00);
  endtask : t_cfg

  task automatic t_single;
    logic [7:0] l;
    logic [2:0] md [3] = '{3'h2, 3'h6, 3'h0};
    setcfg(3'h0, 2'h1);
    chk(o_p4_oe, 8'h00);
    setcfg(3'h1, 2'h1);
    chk(o_p4_oe, 8'hff);
    chk(o_p4_out, 8'ha5);
    for (int i = 0; i < 3; i++) begin
      setcfg(md[i], 2'h0);
      acc(16'h8010, 1'b0, 1'b0, 8'h00, l);
      chk(l, 8'h02);
      chk({7'h0, o_cpu_ext}, 8'h00);
      chk(address_latch_strobe_hi, 8'h00);
    end
  endtask : t_single

  task automatic t_span;
    logic [7:0]  l;
    logic [2:0]  md [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
    logic [15:0] sp [4] = '{16'h0100, 16'h1000, 16'h4000, 16'h7800};
    logic [7:0]  oe [4] = '{8'h00, 8'h0f, 8'h3f, 8'hff};
    for (int i = 0; i < 4; i++) begin
      setcfg(md[i], 2'h0);
      chk(o_p5_oe, oe[i]);
      chk({4'h0, o_p6u_oe}, 8'h0f);
      chk({4'h0, o_p6l_out}, 8'h0a);
      chk({4'h0, o_p6l_oe}, 8'h05);
      acc(16'h8000 + sp[i] - 16'h1, 1'b0, 1'b0, 8'h00, l);
      chk({7'h0, o_cpu_ext}, 8'h01);
      acc(16'h8000 + sp[i], 1'b0, 1'b0, 8'h00, l);
      chk({7'h0, o_cpu_ext}, 8'h00);
      acc(16'h7fff, 1'b0, 1'b0, 8'h00, l);
      chk({7'h0, o_cpu_ext}, 8'h00);
    end
  endtask : t_span

  task automatic t_rw;
    logic [7:0] l;
    setcfg(3'h7, 2'h0);
    xeb_mem_model_i.mem[8'h34] = 8'hc3;
    acc(16'h8134, 1'b0, 1'b0, 8'h00, l);
    chk(o_cpu_rdata, 8'hc3);
    chk(o_p5_out, 8'h81);
    chk(l, 8'h08);
    chk(rd_lo, 8'h03);
    chk(wr_lo, 8'h00);
    chk(address_latch_strobe_hi, 8'h02);
    acc(16'h8156, 1'b1, 1'b0, 8'h5a, l);
    chk(xeb_mem_model_i.mem[8'h56], 8'h5a);
    chk(wr_lo, 8'h03);
    chk(rd_lo, 8'h00);
    setcfg(3'h7, 2'h3);
    acc(16'hf900, 1'b0, 1'b0, 8'h00, l);
    chk(l, 8'h05);
    chk(rd_lo | wr_lo, 8'h00);
    chk(address_latch_strobe_hi, 8'h02);
  endtask : t_rw

  task automatic t_wait;
    logic [7:0] l;
    for (int w = 0; w < 4; w++) begin
      setcfg(3'h7, 2'(w));
      xeb_mem_model_i.mem[8'h20 + 8'(w)] = 8'h60 + 8'(w);
      acc(16'h8020 + 16'(w), 1'b0, 1'b0, 8'h00, l);
      chk(o_cpu_rdata, 8'h60 + 8'(w));
      if (w == 3) begin
        chk({7'h0, l > 8'd11 && l < 8'd31}, 8'h01);
        chk({7'h0, o_p6u_oe[2]}, 8'h00);
      end else begin
        chk(l, (w == 1) ? 8'h09 : 8'h08);
        chk({7'h0, o_p6u_oe[2]}, 8'h01);
      end
    end
  endtask : t_wait

  task automatic t_rmw;
    logic [7:0] l;
    setcfg(3'h7, 2'h0);
    xeb_mem_model_i.mem[8'h78] = 8'h11;
    acc(16'h8178, 1'b0, 1'b1, 8'h99, l);
    chk(o_cpu_rdata, 8'h11);
    chk(xeb_mem_model_i.mem[8'h78], 8'h99);
    chk(l, 8'h0c);
    chk(rd_lo, 8'h03);
    chk(wr_lo, 8'h03);
  endtask : t_rmw

  // clock enable held low for four edges in the address phase
  task automatic t_freeze;
    logic [7:0] l;
    setcfg(3'h7, 2'h0);
    xeb_mem_model_i.mem[8'h42] = 8'h24;
    fork
      acc(16'h8142, 1'b0, 1'b0, 8'h00, l);
      begin
        repeat (3) @(posedge i_ref_clk);
        #1;
        i_clk_en = 1'b0;
        repeat (4) @(posedge i_ref_clk);
        #1;
        i_clk_en = 1'b1;
      end
    join
    chk(l, 8'h0c);
    chk(o_cpu_rdata, 8'h24);
  endtask : t_freeze

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // -----------------------------------------------------------
  // sequence and watchdog
  // -----------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_ref_clk);
    #1;
    chk(o_cfg, 8'h10);
    chk(o_p4_oe, 8'h00);
    i_reset = 1'b0;
    t_cfg();
    t_single();
    t_span();
    t_rw();
    t_wait();
    t_rmw();
    t_freeze();
    give_verdict();
  end

  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule : xeb_bus_tb

// ==== tb/xeb_mem_model.sv ====
`timescale 1ns/1ps
module xeb_mem_model (
  // clock
  input  wire logic       i_ref_clk,
  // bus pins from the device
  input  wire logic [7:0] i_p4_out,
  input  wire logic [3:0] i_p6u_out,
  input  wire logic [3:0] i_p6u_oe,
  // wait length in cycles after each address latch
  input  wire logic [7:0] i_wait_len,
  // lines back to the device
  output logic      [7:0] o_p4_in,
  output logic            o_wait_n
);
  logic [7:0] mem [0:255];
  logic [7:0] lat_lo = 8'h00;
  logic [7:0] last   = 8'h00;
  logic [7:0] wcnt   = 8'h00;
  logic       address_latch_strobe_q = 1'b0;
  wire        rd_act = i_p6u_oe[0] & ~i_p6u_out[0];
  wire        wr_act = i_p6u_oe[1] & ~i_p6u_out[1];
  wire        address_latch_strobe   = i_p6u_oe[3] & i_p6u_out[3];

  // -----------------------------------------------------------
  // bus behaviour
  // -----------------------------------------------------------
  // data only while read strobe is low; a released bus shows the
  // inverse of the last byte so stale data never passes
  assign o_p4_in  = rd_act ? mem[lat_lo] : ~last;
  assign o_wait_n = (wcnt == 8'h00);

  always @(posedge i_ref_clk) begin
    address_latch_strobe_q <= address_latch_strobe;
    if (address_latch_strobe_q && !address_latch_strobe) begin
      lat_lo <= i_p4_out;
      wcnt   <= i_wait_len;
    end else if (wcnt != 8'h00) begin
      wcnt <= wcnt - 8'h01;
    end
    if (rd_act) last <= mem[lat_lo];
    if (wr_act) mem[lat_lo] <= i_p4_out;
  end
endmodule : xeb_mem_model
